// ### hw/rak_defines.vh
// rak_defines.vh: register map, field positions and timing counts for the ramp and amplitude keying block
// assumes inclusion by the design files only
`ifndef RAK_DEFINES_VH
`define RAK_DEFINES_VH

// byte addresses of the register map, one 32-bit word apart up to status, then the bounds of the profile window
`define RAK_ADDR_CTRL1 8'h00
`define RAK_ADDR_CTRL2 8'h04
`define RAK_ADDR_UPDATE 8'h08
`define RAK_ADDR_LIM_LO 8'h0c
`define RAK_ADDR_LIM_HI 8'h10
`define RAK_ADDR_STEP_P 8'h14
`define RAK_ADDR_STEP_N 8'h18
`define RAK_ADDR_RATE 8'h1c
`define RAK_ADDR_STATUS 8'h20
`define RAK_ADDR_PROF_BASE 8'h40
`define RAK_ADDR_PROF_END 8'h5c

// control word one fields
`define RAK_BIT_AK_EN 8
`define RAK_BIT_AK_EXT 9
`define RAK_BIT_CLR_ACC 12
`define RAK_BIT_AUTOCLR 13
`define RAK_BIT_LOAD_RATE 15
// control word two fields
`define RAK_BIT_RAMP_EN 19
`define RAK_BIT_DEST_LO 20
`define RAK_BIT_DEST_HI 21

// ramp destination codes
`define RAK_DEST_FREQ 2'b00
`define RAK_DEST_PHASE 2'b01

// profile register layout: amplitude scale factor in [27:16], phase in [15:0]
`define RAK_ASF_LO 16
`define RAK_ASF_HI 27
`define RAK_POW_HI 15

// axi response codes
`define RAK_RESP_OKAY 2'b00
`define RAK_RESP_SLVERR 2'b10

// reset values
`define RAK_ZERO32 32'h0000_0000
`define RAK_RATE_ONE 16'h0001

`endif

// ### hw/rak_sync.v
// rak_sync.v: two-stage synchroniser for a bus of pin levels
// assumes the pins are asynchronous to aclk
module rak_sync #(
    parameter WIDTH = 6
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pins and synchronised levels
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_sync
);

reg [WIDTH-1:0] meta_reg;

always @(posedge aclk) begin
    if (!aresetn) begin
        meta_reg <= {WIDTH{1'b0}};
        pin_sync <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= pin_in;
        pin_sync <= meta_reg;
    end
end

endmodule // rak_sync

// ### hw/rak_core.v
// rak_core.v: amplitude keying and ramp generator front end with an axi4-lite register slave
// assumes one clock aclk, synchronous low reset, pins from an outside controller
`include "rak_defines.vh"
module rak_core (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // external pins
    input wire amplitude_keying_pin,
    input wire [2:0] profile_pin,
    input wire ramp_direction_pin,
    input wire ramp_hold_pin,
    input wire io_update_pin,
    // synthesis parameters
    output reg [31:0] freq_word,
    output reg [15:0] phase_word,
    output reg [11:0] amp_word
);

// pin synchroniser
wire [6:0] pins_sync;
wire ak_pin_s = pins_sync[0];
wire [2:0] prof_s = pins_sync[3:1];
wire dir_s = pins_sync[4];
wire hold_s = pins_sync[5];
wire upd_s = pins_sync[6];

rak_sync #(.WIDTH(7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({io_update_pin, ramp_hold_pin, ramp_direction_pin, profile_pin, amplitude_keying_pin}),
    .pin_sync(pins_sync)
);

// staged and active register sets
reg [31:0] control_word_one_reg;
reg [31:0] control_word_two_reg;
reg [31:0] lim_lo_reg;
reg [31:0] lim_hi_reg;
reg [31:0] step_p_reg;
reg [31:0] step_n_reg;
reg [31:0] rate_reg;
reg [31:0] prof_mem [0:7];
reg [31:0] act_one_reg;
reg [31:0] act_two_reg;
reg upd_prev_reg;
reg sw_upd_reg;

// byte-lane merge
function [31:0] rak_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
        rak_merge = old_v;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                rak_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    end
endfunction

// profile window decode
function rak_is_prof;
    input [7:0] addr;
    begin
        rak_is_prof = (addr >= `RAK_ADDR_PROF_BASE) && (addr <= `RAK_ADDR_PROF_END) && (addr[1:0] == 2'b00);
    end
endfunction

// axi write side: latch address and data in either order
reg [7:0] aw_addr_reg;
reg aw_full_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_full_reg;
assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
wire wr_known = (aw_addr_reg <= `RAK_ADDR_RATE) || rak_is_prof(aw_addr_reg);
integer k;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_addr_reg <= 8'h00;
        aw_full_reg <= 1'b0;
        w_data_reg <= `RAK_ZERO32;
        w_strb_reg <= 4'h0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RAK_RESP_OKAY;
        control_word_one_reg <= `RAK_ZERO32;
        control_word_two_reg <= `RAK_ZERO32;
        lim_lo_reg <= `RAK_ZERO32;
        lim_hi_reg <= `RAK_ZERO32;
        step_p_reg <= `RAK_ZERO32;
        step_n_reg <= `RAK_ZERO32;
        rate_reg <= {`RAK_RATE_ONE, `RAK_RATE_ONE};
        sw_upd_reg <= 1'b0;
        for (k = 0; k < 8; k = k + 1) begin
            prof_mem[k] <= `RAK_ZERO32;
        end
    end else begin
        sw_upd_reg <= 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            aw_full_reg <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
        end
        if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `RAK_RESP_OKAY : `RAK_RESP_SLVERR;
            case (aw_addr_reg)
                `RAK_ADDR_CTRL1: begin
                    control_word_one_reg <= rak_merge(control_word_one_reg, w_data_reg, w_strb_reg);
                end
                `RAK_ADDR_CTRL2: begin
                    control_word_two_reg <= rak_merge(control_word_two_reg, w_data_reg, w_strb_reg);
                end
                `RAK_ADDR_UPDATE: begin
                    sw_upd_reg <= w_data_reg[0];
                end
                `RAK_ADDR_LIM_LO: begin
                    lim_lo_reg <= rak_merge(lim_lo_reg, w_data_reg, w_strb_reg);
                end
                `RAK_ADDR_LIM_HI: begin
                    lim_hi_reg <= rak_merge(lim_hi_reg, w_data_reg, w_strb_reg);
                end
                `RAK_ADDR_STEP_P: begin
                    step_p_reg <= rak_merge(step_p_reg, w_data_reg, w_strb_reg);
                end
                `RAK_ADDR_STEP_N: begin
                    step_n_reg <= rak_merge(step_n_reg, w_data_reg, w_strb_reg);
                end
                `RAK_ADDR_RATE: begin
                    rate_reg <= rak_merge(rate_reg, w_data_reg, w_strb_reg);
                end
                default: begin
                    if (rak_is_prof(aw_addr_reg)) begin
                        prof_mem[aw_addr_reg[4:2]] <= rak_merge(prof_mem[aw_addr_reg[4:2]], w_data_reg, w_strb_reg);
                    end
                end
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// update event: pin rising edge or software strobe
wire upd_evt = (upd_s && !upd_prev_reg) || sw_upd_reg;

// active set loads on update only
always @(posedge aclk) begin
    if (!aresetn) begin
        act_one_reg <= `RAK_ZERO32;
        act_two_reg <= `RAK_ZERO32;
        upd_prev_reg <= 1'b0;
    end else begin
        upd_prev_reg <= upd_s;
        if (upd_evt) begin
            act_one_reg <= control_word_one_reg;
            act_two_reg <= control_word_two_reg;
        end
    end
end

wire ak_en = act_one_reg[`RAK_BIT_AK_EN];
wire ak_ext = act_one_reg[`RAK_BIT_AK_EXT];
wire clr_acc = act_one_reg[`RAK_BIT_CLR_ACC];
wire load_rate = act_one_reg[`RAK_BIT_LOAD_RATE];
wire ramp_en = act_two_reg[`RAK_BIT_RAMP_EN];
wire [1:0] dest = act_two_reg[`RAK_BIT_DEST_HI:`RAK_BIT_DEST_LO];

// ramp generator
reg [31:0] acc_reg;
reg [15:0] timer_reg;
reg dir_prev_reg;
reg en_prev_reg;
reg autoclr_pend_reg;
wire [31:0] up_sum = acc_reg + step_p_reg;
wire [31:0] dn_dif = acc_reg - step_n_reg;
wire up_ovf = up_sum < acc_reg;
wire dn_unf = dn_dif > acc_reg;
wire dir_chg = dir_s != dir_prev_reg;
wire en_rise = ramp_en && !en_prev_reg;
wire [15:0] rate_sel = dir_s ? rate_reg[15:0] : rate_reg[31:16];

always @(posedge aclk) begin
    if (!aresetn) begin
        acc_reg <= `RAK_ZERO32;
        timer_reg <= `RAK_RATE_ONE;
        dir_prev_reg <= 1'b0;
        en_prev_reg <= 1'b0;
        autoclr_pend_reg <= 1'b0;
    end else begin
        en_prev_reg <= ramp_en;
        autoclr_pend_reg <= upd_evt && control_word_one_reg[`RAK_BIT_AUTOCLR];
        if (ramp_en) begin
            dir_prev_reg <= dir_s;
            if (clr_acc || autoclr_pend_reg || (en_rise && !dir_s)) begin
                acc_reg <= lim_lo_reg;
                timer_reg <= rate_sel;
            end else if (en_rise || dir_chg || (upd_evt && load_rate)) begin
                timer_reg <= rate_sel;
            end else if (!hold_s) begin
                if (timer_reg > 16'h0001) begin
                    timer_reg <= timer_reg - 16'h0001;
                end else begin
                    timer_reg <= rate_sel;
                    if (dir_s) begin
                        acc_reg <= (up_ovf || up_sum > lim_hi_reg) ? lim_hi_reg : up_sum;
                    end else begin
                        acc_reg <= (dn_unf || dn_dif < lim_lo_reg) ? lim_lo_reg : dn_dif;
                    end
                end
            end
            if (acc_reg > lim_hi_reg) begin
                acc_reg <= lim_hi_reg;
            end else if (acc_reg < lim_lo_reg) begin
                acc_reg <= lim_lo_reg;
            end
        end
    end
end

// output mux
wire [31:0] prof_sel = prof_mem[prof_s];
always @(posedge aclk) begin
    if (!aresetn) begin
        freq_word <= `RAK_ZERO32;
        phase_word <= 16'h0000;
        amp_word <= 12'h000;
    end else begin
        phase_word <= prof_sel[`RAK_POW_HI:0];
        amp_word <= prof_sel[`RAK_ASF_HI:`RAK_ASF_LO];
        freq_word <= `RAK_ZERO32;
        if (ramp_en) begin
            case (dest)
                `RAK_DEST_FREQ: begin
                    freq_word <= acc_reg;
                end
                `RAK_DEST_PHASE: begin
                    phase_word <= {acc_reg[31:18], 2'b00};
                end
                default: begin
                    amp_word <= acc_reg[31:20];
                end
            endcase
        end
        if (ak_en) begin
            if (ak_ext && !ak_pin_s) begin
                amp_word <= 12'h000;
            end else begin
                amp_word <= prof_sel[`RAK_ASF_HI:`RAK_ASF_LO];
            end
        end
    end
end

// axi read side
reg [31:0] rd_val;
reg rd_ok;
assign s_axi_arready = !s_axi_rvalid;
always @* begin
    rd_ok = 1'b1;
    rd_val = `RAK_ZERO32;
    case ({s_axi_araddr[7:2], 2'b00})
        `RAK_ADDR_CTRL1: rd_val = control_word_one_reg;
        `RAK_ADDR_CTRL2: rd_val = control_word_two_reg;
        `RAK_ADDR_UPDATE: rd_val = `RAK_ZERO32;
        `RAK_ADDR_LIM_LO: rd_val = lim_lo_reg;
        `RAK_ADDR_LIM_HI: rd_val = lim_hi_reg;
        `RAK_ADDR_STEP_P: rd_val = step_p_reg;
        `RAK_ADDR_STEP_N: rd_val = step_n_reg;
        `RAK_ADDR_RATE: rd_val = rate_reg;
        `RAK_ADDR_STATUS: rd_val = acc_reg;
        default: begin
            if (rak_is_prof({s_axi_araddr[7:2], 2'b00})) begin
                rd_val = prof_mem[s_axi_araddr[4:2]];
            end else begin
                rd_ok = 1'b0;
            end
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `RAK_ZERO32;
        s_axi_rresp <= `RAK_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `RAK_RESP_OKAY : `RAK_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // rak_core

// ### verification/rak_core_properties.sv
// rak_core_properties.sv: bus handshake and pin timing checks for the keying and ramp block
// assumes it is bound to rak_core and sees only its ports
module rak_core_properties (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // pins and parameters
    input logic amplitude_keying_pin,
    input logic [2:0] profile_pin,
    input logic ramp_hold_pin,
    input logic io_update_pin,
    input logic [31:0] freq_word,
    input logic [11:0] amp_word
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // helper terms
    wire aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ar_go = s_axi_arvalid && s_axi_arready;
    wire quiet = ramp_hold_pin && !io_update_pin && !s_axi_awvalid;
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    write_answer_a: assert property (aw_go |-> ##2 s_axi_bvalid) else $error("no write response");
    read_answer_a: assert property (ar_go |=> s_axi_rvalid) else $error("no read data");
    write_unmapped_a: assert property (aw_go && s_axi_awaddr == 8'h3c |-> ##2 s_axi_bresp == 2'h2)
        else $error("unmapped write not refused");
    read_unmapped_a: assert property (ar_go && s_axi_araddr == 8'h3c |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken with response pending");
    hold_freeze_a: assert property (quiet[*6] |-> $stable(freq_word))
        else $error("ramp moved while held");
    pin_sync_a: assert property (
        quiet[*6] ##0 (!$stable(amplitude_keying_pin) || !$stable(profile_pin)) |=> $stable(amp_word)[*2])
        else $error("pin acted before synchronisation");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (amp_word == 12'habc);
    cover property (quiet[*6] ##1 !$stable(amp_word));
endmodule // rak_core_properties

bind rak_core rak_core_properties chk (.*);

// ### verification/rak_pin_model.sv
// rak_pin_model.sv: outside controller driving keying, profile, ramp and update pins
// assumes calls come just after a rising clock edge
module rak_pin_model (
    // pins toward the block
    output logic amplitude_keying_pin,
    output logic [2:0] profile_pin,
    output logic ramp_direction_pin,
    output logic ramp_hold_pin,
    output logic io_update_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {amplitude_keying_pin, profile_pin, ramp_direction_pin, ramp_hold_pin, io_update_pin} = 7'h00;
    task automatic drive(input logic k, input logic [2:0] p, input logic dr, input logic h);
        amplitude_keying_pin <= k;
        profile_pin <= p;
        ramp_direction_pin <= dr;
        ramp_hold_pin <= h;
    endtask
    task automatic update_level(input logic u);
        io_update_pin <= u;
    endtask
endmodule // rak_pin_model

// ### verification/rak_core_bench.sv
// rak_core_bench.sv: directed test of register access, keying and ramp routing
// assumes rak_core, pins from rak_pin_model, a 100 MHz clock
module rak_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, freq_word, d, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] phase_word;
    logic [11:0] amp_word;
    logic amplitude_keying_pin, ramp_direction_pin, ramp_hold_pin, io_update_pin;
    logic [2:0] profile_pin;
    int n_mismatch = 0, tests_run = 0;
    localparam logic [31:0] lim_lo = 32'h1234_5678, lim_hi = 32'h1234_6000;
    always #5 aclk = ~aclk;
    rak_core uut (.*);
    rak_pin_model ctl (.*);
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tk(input int c);
        repeat (c) @(posedge aclk);
    endtask
    task automatic guard(input int c);
        if (c >= 300) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] wd);
        int c;
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (c = 0; c < 300; c++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        guard(c);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a);
        int c;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (c = 0; c < 300; c++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        guard(c);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic upd();
        ctl.update_level(1'h1);
        tk(3);
        ctl.update_level(1'h0);
        tk(8);
    endtask
    task automatic until_freq(input logic [31:0] e);
        int c;
        for (c = 0; c < 300 && freq_word !== e; c++) @(posedge aclk);
        guard(c);
    endtask
    initial begin
        tk(8);
        aresetn <= 1'h1;
        tk(1);
        axr(8'h1c);
        check("rate", d, 32'h0001_0001);
        axr(8'h3c);
        check("rresp", 32'(r), 32'h2);
        axw(8'h3c, 32'hffff_ffff);
        check("bresp", 32'(r), 32'h2);
        axw(8'h0c, lim_lo);
        axw(8'h10, lim_hi);
        axw(8'h14, 32'h0000_0100);
        axw(8'h18, 32'h0000_0100);
        axw(8'h1c, 32'h0003_0002);
        axw(8'h4c, 32'h0abc_1234);
        axw(8'h54, 32'h05a5_0000);
        axw(8'h04, 32'h0008_0000);
        tk(10);
        check("freq", freq_word, 32'h0);
        upd();
        check("freq", freq_word, lim_lo);
        ctl.drive(1'h0, 3'h3, 1'h1, 1'h0);
        until_freq(lim_hi);
        tk(12);
        check("freq", freq_word, lim_hi);
        ctl.drive(1'h0, 3'h3, 1'h0, 1'h0);
        tk(12);
        ctl.drive(1'h0, 3'h3, 1'h0, 1'h1);
        tk(6);
        v = freq_word;
        tk(20);
        check("hold", freq_word, v);
        check("mid", 32'(v > lim_lo && v < lim_hi), 32'h1);
        ctl.drive(1'h0, 3'h3, 1'h0, 1'h0);
        until_freq(lim_lo);
        tk(9);
        check("freq", freq_word, lim_lo);
        ctl.drive(1'h0, 3'h3, 1'h0, 1'h1);
        axw(8'h04, 32'h0018_0000);
        upd();
        check("phase", 32'(phase_word), 32'h1234);
        check("freq", freq_word, 32'h0);
        axw(8'h04, 32'h0028_0000);
        axw(8'h00, 32'h0000_0200);
        upd();
        check("amp", 32'(amp_word), 32'h123);
        axw(8'h00, 32'h0000_0300);
        upd();
        check("amp", 32'(amp_word), 32'h0);
        ctl.drive(1'h1, 3'h3, 1'h0, 1'h1);
        tk(6);
        check("amp", 32'(amp_word), 32'habc);
        ctl.drive(1'h1, 3'h5, 1'h0, 1'h1);
        tk(6);
        check("amp", 32'(amp_word), 32'h5a5);
        axr(8'h20);
        check("status", d, lim_lo);
        ctl.drive(1'h1, 3'h5, 1'h1, 1'h0);
        tk(30);
        axr(8'h20);
        check("status", d, lim_hi);
        axw(8'h00, 32'h0000_1000);
        axw(8'h08, 32'h0000_0001);
        tk(4);
        axr(8'h20);
        check("status", d, lim_lo);
        check("amp", 32'(amp_word), 32'h123);
        conclude();
    end
endmodule // rak_core_bench
